// File: logic/frame_align_pkg.sv
// package: constants and carriers for the serial frame alignment monitor
package frame_align_pkg;
   // ----------------------------------------
   // code values and field layout
   // ----------------------------------------
   localparam int SAMPLE_W = 16;
   localparam int OCTET_W = 8;
   localparam int MSB_LO = 8; // low bit of the first octet
   localparam logic [7:0] D28_7 = 8'hfc; // data octet that mode 2 replaces
   localparam logic [7:0] K28_7 = 8'hfc; // control octet sent with k flag
   localparam logic [7:0] K28_5 = 8'hbc; // comma octet
   localparam logic [7:0] D21_5 = 8'hb5; // alternating 1010101010 code group
   localparam logic [14:0] PRBS15_SEED = 15'h7fff;
   localparam logic [10:0] PRBS11_SEED = 11'h7ff;
   localparam int FIFO_DEPTH = 8;

   // ----------------------------------------
   // modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      PAT_DATA, PAT_ALT, PAT_PRBS11, PAT_PRBS15
   } pattern_e;
   typedef enum logic [1:0] {
      RANGE_LOW, RANGE_MID, RANGE_HIGH
   } rate_range_e;

   // one outgoing code-group pair before 8b/10b encoding
   typedef struct packed {
      logic [7:0] first; // octet of code group one, sent first
      logic first_k; // first octet is a control character
      logic [7:0] second; // octet of code group two
      logic second_k; // second octet is a control character
   } frame_s;
endpackage : frame_align_pkg

// File: logic/frame_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module frame_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [AW-1:0] wr_ptr; // write index
   logic [AW-1:0] rd_ptr; // read index
   logic [AW:0] count; // words held
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr]; // read data comes from registered storage

   // storage writes, no reset needed on data
   always_ff @(posedge core_clk) begin
      if (clk_en && push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : frame_fifo

// File: logic/serial_frame_align_monitor.sv
// transmit framing: octet split, alignment-monitor substitution, test patterns
// ----------------------------------------
// Functional notes
// - high octet first, low octet second
// - scramble enable scrambles both octets
// - preamble only after request held two cycles
// - monitor enable allows k28.7 on octet two
// - mode 1: repeat of second octet sends k28.7
// - mode 1: never k28.7 in consecutive frames
// - mode 2: d28.7 second octet becomes k28.7
// - monitor disabled: no substitutions at all
// - rate select pins pick pll range
// - pattern select picks data or test pattern
// - held sync request gives k28.5 stream
// ----------------------------------------
`timescale 1ns/1ps
module serial_frame_align_monitor #(
   parameter int SAMPLE_W = frame_align_pkg::SAMPLE_W,
   parameter int FIFO_DEPTH = frame_align_pkg::FIFO_DEPTH
) (
   input wire logic core_clk, // sample encode clock
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [SAMPLE_W-1:0] sample_data, // sample stream in
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic align_monitor_enable,
   input wire logic scramble_enable,
   input wire logic sync_request, // from receiver pin, asynchronous
   input wire logic pattern_select_lo,
   input wire logic pattern_select_hi,
   input wire logic rate_range_select_lo,
   input wire logic rate_range_select_hi,
   output frame_align_pkg::rate_range_e pll_range,
   output frame_align_pkg::frame_s frame_out, // pair for the encoder
   output logic frame_valid,
   input wire logic frame_ready,
   output logic preamble_active
);
   // ----------------------------------------
   // sync request synchroniser and qualification
   // ----------------------------------------
   logic sync_ff1; // first stage, read only by sync_ff2
   logic sync_ff2;
   logic sync_ff3;
   logic sync_level; // accepted level, changes when stages 2 and 3 agree
   logic sync_held; // request seen active on the previous encode cycle

   // three stage synchroniser for the pin
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_ff1 <= 1'b0;
         sync_ff2 <= 1'b0;
         sync_ff3 <= 1'b0;
         sync_level <= 1'b0;
      end else if (clk_en) begin
         sync_ff1 <= sync_request;
         sync_ff2 <= sync_ff1;
         sync_ff3 <= sync_ff2;
         if (sync_ff2 == sync_ff3) begin
            sync_level <= sync_ff3;
         end
      end
   end

   // a one-cycle glitch on the request never starts a preamble
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_held <= 1'b0;
      end else if (clk_en) begin
         sync_held <= sync_level;
      end
   end
   wire preamble_start = sync_level && sync_held;
   // a held request keeps the comma stream going, usable as a test pattern
   wire send_comma = preamble_start;

   // ----------------------------------------
   // pin decode
   // ----------------------------------------
   wire frame_align_pkg::pattern_e pattern =
      frame_align_pkg::pattern_e'({pattern_select_hi, pattern_select_lo});
   // select 0 is a don't care when select 1 is low
   assign pll_range = !rate_range_select_hi ? frame_align_pkg::RANGE_LOW :
      (rate_range_select_lo ? frame_align_pkg::RANGE_HIGH :
       frame_align_pkg::RANGE_MID);
   wire mode1 = align_monitor_enable && !scramble_enable;
   wire mode2 = align_monitor_enable && scramble_enable;

   // ----------------------------------------
   // sample buffer
   // ----------------------------------------
   logic [SAMPLE_W-1:0] buf_data;
   logic buf_valid;
   logic buf_ready;
   frame_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .in_data(sample_data),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(buf_ready)
   );

   // ----------------------------------------
   // output stage handshake
   // ----------------------------------------
   wire advance = !frame_valid || frame_ready; // output register free
   // samples are dropped while the preamble runs, as resync loses data
   assign buf_ready = advance && (send_comma || pattern == frame_align_pkg::PAT_DATA);
   wire take_sample = buf_valid && buf_ready && !send_comma;
   wire test_step = advance && !send_comma && pattern != frame_align_pkg::PAT_DATA;
   wire emit = send_comma ? advance : (take_sample || test_step);

   // ----------------------------------------
   // scrambler 1+x^14+x^15, sixteen bits per frame
   // ----------------------------------------
   logic [14:0] scr_state;
   logic [14:0] scr_next;
   logic [15:0] scr_out;
   // parallel form: each output bit folds back into the register
   always_comb begin
      logic [14:0] s;
      s = scr_state;
      for (int i = 15; i >= 0; i--) begin
         scr_out[i] = buf_data[i] ^ s[14] ^ s[13];
         s = {s[13:0], scr_out[i]};
      end
      scr_next = s;
   end
   // scrambler only advances with real sample frames
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scr_state <= frame_align_pkg::PRBS15_SEED;
      end else if (clk_en && take_sample && scramble_enable) begin
         scr_state <= scr_next;
      end
   end
   wire [15:0] payload = scramble_enable ? scr_out : buf_data;
   wire [7:0] octet_one = payload[frame_align_pkg::MSB_LO +: frame_align_pkg::OCTET_W];
   wire [7:0] octet_two = payload[frame_align_pkg::OCTET_W-1:0];

   // ----------------------------------------
   // test pattern generators
   // ----------------------------------------
   logic [10:0] prbs11;
   logic [14:0] prbs15;
   // generators step one frame (sixteen bits) at a time
   function automatic logic [10:0] step11(input logic [10:0] v);
      logic [10:0] r;
      r = v;
      for (int i = 0; i < 16; i++) begin
         r = {r[9:0], r[10] ^ r[8]};
      end
      return r;
   endfunction : step11
   function automatic logic [14:0] step15(input logic [14:0] v);
      logic [14:0] r;
      r = v;
      for (int i = 0; i < 16; i++) begin
         r = {r[13:0], r[14] ^ r[13]};
      end
      return r;
   endfunction : step15
   // both step while any test pattern is selected, one step per frame sent
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prbs11 <= frame_align_pkg::PRBS11_SEED;
         prbs15 <= frame_align_pkg::PRBS15_SEED;
      end else if (clk_en && test_step) begin
         prbs11 <= step11(prbs11);
         prbs15 <= step15(prbs15);
      end
   end

   // ----------------------------------------
   // alignment monitor substitution
   // ----------------------------------------
   logic [7:0] prev_second; // previous frame's real second octet
   logic prev_k; // previous frame carried k28.7
   wire sub_mode1 = mode1 && octet_two == prev_second && !prev_k;
   wire sub_mode2 = mode2 && octet_two == frame_align_pkg::D28_7;
   wire substitute = align_monitor_enable && (sub_mode1 || sub_mode2);

   // history for the mode 1 comparison, one update per sample frame
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prev_second <= '0;
         prev_k <= 1'b1; // no mode 1 substitution on the very first frame
      end else if (clk_en && take_sample) begin
         prev_second <= octet_two;
         prev_k <= substitute;
      end
   end

   // ----------------------------------------
   // frame select
   // ----------------------------------------
   frame_align_pkg::frame_s next_frame;
   always_comb begin
      next_frame = '0;
      if (send_comma) begin
         next_frame = '{frame_align_pkg::K28_5, 1'b1, frame_align_pkg::K28_5, 1'b1};
      end else begin
         unique case (pattern)
            frame_align_pkg::PAT_DATA: begin
               next_frame.first = octet_one;
               next_frame.second = substitute ? frame_align_pkg::K28_7 : octet_two;
               next_frame.second_k = substitute;
            end
            frame_align_pkg::PAT_ALT: begin
               next_frame.first = frame_align_pkg::D21_5;
               next_frame.second = frame_align_pkg::D21_5;
            end
            frame_align_pkg::PAT_PRBS11: begin
               next_frame.first = prbs11[10:3];
               next_frame.second = {prbs11[2:0], prbs11[10:6]};
            end
            frame_align_pkg::PAT_PRBS15: begin
               next_frame.first = prbs15[14:7];
               next_frame.second = prbs15[7:0];
            end
         endcase
      end
   end

   // output register toward the encoder
   always_ff @(posedge core_clk) begin
      if (rst) begin
         frame_out <= '0;
         frame_valid <= 1'b0;
         preamble_active <= 1'b0;
      end else if (clk_en && advance) begin
         frame_valid <= emit;
         preamble_active <= emit && send_comma;
         if (emit) begin
            frame_out <= next_frame;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_two_cycle_sync;
      @(posedge core_clk) disable iff (rst || !clk_en)
      $rose(preamble_active) |-> $past(sync_level) && $past(sync_held);
   endproperty
   a_two_cycle_sync: assert property (p_two_cycle_sync) else $error("preamble too early");

   property p_msb_first;
      @(posedge core_clk) disable iff (rst)
      (clk_en && take_sample && advance && pattern == frame_align_pkg::PAT_DATA)
      |=> frame_out.first == $past(buf_data[15:8]) || scramble_enable;
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first octet not msb");

   property p_no_double_k;
      @(posedge core_clk) disable iff (rst)
      (clk_en && take_sample && prev_k && mode1) |-> !substitute;
   endproperty
   a_no_double_k: assert property (p_no_double_k) else $error("k28.7 twice in mode 1");

   property p_mode1_sub;
      @(posedge core_clk) disable iff (rst)
      (mode1 && !prev_k && octet_two == prev_second) |-> substitute;
   endproperty
   a_mode1_sub: assert property (p_mode1_sub) else $error("mode 1 missed k28.7");

   property p_mode2_sub;
      @(posedge core_clk) disable iff (rst)
      mode2 |-> (substitute == (octet_two == frame_align_pkg::D28_7));
   endproperty
   a_mode2_sub: assert property (p_mode2_sub) else $error("mode 2 substitution wrong");

   property p_off_no_sub;
      @(posedge core_clk) disable iff (rst)
      (frame_valid && frame_out.second_k && !preamble_active)
      |-> $past(align_monitor_enable) || $past(!clk_en);
   endproperty
   a_off_no_sub: assert property (p_off_no_sub) else $error("k28.7 with monitor off");

   property p_history;
      @(posedge core_clk) disable iff (rst)
      (clk_en && take_sample) |=> prev_second == $past(octet_two) && prev_k == $past(substitute);
   endproperty
   a_history: assert property (p_history) else $error("history not updated");

   property p_comma;
      @(posedge core_clk) disable iff (rst)
      (clk_en && send_comma && advance) |=> frame_out.first == frame_align_pkg::K28_5 && frame_out.first_k;
   endproperty
   a_comma: assert property (p_comma) else $error("comma not sent");

   property p_range;
      @(posedge core_clk) (rate_range_select_hi && rate_range_select_lo) |-> pll_range == frame_align_pkg::RANGE_HIGH;
   endproperty
   a_range: assert property (p_range) else $error("pll range wrong");

   c_mode1: cover property (@(posedge core_clk) mode1 && take_sample && substitute);
   c_mode2: cover property (@(posedge core_clk) mode2 && take_sample && substitute);
   c_preamble: cover property (@(posedge core_clk) preamble_active ##1 !preamble_active);
   c_prbs: cover property (@(posedge core_clk) pattern == frame_align_pkg::PAT_PRBS15 && frame_valid);
endmodule : serial_frame_align_monitor

// File: sim/frame_rx_model.sv
// receiver model: takes frames and undoes the alignment-monitor substitutions
`timescale 1ns/1ps
module frame_rx_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en, // a frozen encode edge completes no transfer
   input wire frame_align_pkg::frame_s frame_out,
   input wire logic frame_valid,
   output logic frame_ready,
   input wire logic stall, // bench asks for a slow receiver
   input wire logic want_sync, // bench asks for a resync
   input wire logic mode2, // scrambling on: descramble, k28.7 means d28.7
   output logic sync_request,
   output logic [15:0] rx_sample, // sample rebuilt from the pair
   output logic rx_valid,
   output logic realign // two k28.7 in a row where code group one belongs
);
   // ----------------------------------------
   // handshake and restore
   // ----------------------------------------
   logic [7:0] last_second; // octet decoded at position two last frame
   logic [7:0] restored; // second octet after undoing k28.7
   logic [15:0] coded; // pair as received, high octet first
   logic [15:0] plain; // pair after descrambling
   logic [14:0] dsc_state; // descrambler history, fed by received bits
   logic [14:0] dsc_next;
   logic first_k287; // k28.7 found at position one
   logic k_first_seen; // the previous frame had one there too
   logic take; // a pair changes hands on this edge
   assign first_k287 = frame_out.first_k && frame_out.first == frame_align_pkg::K28_7;
   assign take = frame_valid && frame_ready && clk_en;
   // both follow bench wishes, which change just after an edge
   assign frame_ready = !stall;
   assign sync_request = want_sync; // resync may be asked at any moment
   // mode 2 maps back to d28.7, mode 1 repeats the previous octet
   assign restored = !frame_out.second_k ? frame_out.second :
      (mode2 ? frame_align_pkg::D28_7 : last_second);

   // self-aligning descrambler: a wrong start value heals within one frame
   always_comb begin
      logic [14:0] d;
      d = dsc_state;
      coded = {frame_out.first, restored};
      for (int i = 15; i >= 0; i--) begin
         plain[i] = coded[i] ^ d[14] ^ d[13];
         d = {d[13:0], coded[i]};
      end
      dsc_next = d;
   end

   // take one pair per accepted transfer; comma pairs carry no sample
   always_ff @(posedge core_clk) begin
      if (rst) begin
         last_second <= 8'h00;
         dsc_state <= frame_align_pkg::PRBS15_SEED;
         k_first_seen <= 1'b0;
         realign <= 1'b0;
         rx_sample <= 16'h0000;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (take) begin
            k_first_seen <= first_k287;
            // a second misplaced k28.7 would move the frame boundary here
            realign <= realign || (k_first_seen && first_k287);
         end
         if (take && !frame_out.first_k) begin
            rx_sample <= mode2 ? plain : coded; // first octet is the high one
            last_second <= restored;
            if (mode2) begin
               dsc_state <= dsc_next;
            end
            rx_valid <= 1'b1;
         end
      end
   end
endmodule : frame_rx_model

// File: sim/serial_frame_align_monitor_test.sv
// self-checking bench for the serial frame alignment monitor
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   n_tests++; \
   if ((got) !== (exp)) begin \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
      failures++; \
   end
module serial_frame_align_monitor_test;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1; // random freezes come from the driver
   logic [15:0] sample_data = 16'h0000;
   logic sample_valid = 1'b0, sample_ready, mon = 1'b0, scr = 1'b0;
   logic want_sync = 1'b0, stall = 1'b0, hold_stall = 1'b0, feed = 1'b0;
   logic [1:0] pat = 2'b00, rsel = 2'b00;
   frame_align_pkg::rate_range_e pll_range, er;
   frame_align_pkg::frame_s frame_out;
   logic frame_valid, frame_ready, preamble_active, sync_request, rx_valid, took, realign;
   logic [15:0] rx_sample, s, exp_rx, prev;
   logic [31:0] rnd = 32'h470a0f43;
   int failures = 0, n_tests = 0, cycles = 0;
   logic check_on = 1'b0, rx_chk = 1'b0, pk = 1'b1, k, seen;
   logic [7:0] ps = 8'h00; // model history: last real second octet
   logic [15:0] q[$]; // samples taken, not yet framed

   always #2.5 core_clk = ~core_clk;

   serial_frame_align_monitor dut_u (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .align_monitor_enable(mon), .scramble_enable(scr), .sync_request(sync_request),
      .pattern_select_lo(pat[0]), .pattern_select_hi(pat[1]),
      .rate_range_select_lo(rsel[0]), .rate_range_select_hi(rsel[1]),
      .pll_range(pll_range), .frame_out(frame_out), .frame_valid(frame_valid),
      .frame_ready(frame_ready), .preamble_active(preamble_active));

   frame_rx_model rx_u (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .frame_out(frame_out),
      .frame_valid(frame_valid), .frame_ready(frame_ready), .stall(stall),
      .want_sync(want_sync), .mode2(scr), .sync_request(sync_request),
      .rx_sample(rx_sample), .rx_valid(rx_valid), .realign(realign));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // random driver; a sample is held until the edge that takes it
   always @(posedge core_clk) begin
      took = sample_valid && sample_ready && clk_en;
      #1;
      rnd = lfsr(rnd);
      stall = hold_stall || (rnd[3] && rnd[4]);
      clk_en = !(rnd[9] && rnd[10] && rnd[11]); // frozen about one edge in eight
      if (!sample_valid || took) begin
         sample_valid = feed && (rnd[5] || rnd[6]);
         // two low octets only, so repeats are frequent without scrambling
         sample_data = {rnd[15:8], scr ? rnd[23:16] : {7'h1e, rnd[7]}};
      end
   end

   // ----------------------------------------
   // reference model and scoreboard
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         q.delete();
         pk = 1'b1; // first frame after reset is never substituted in mode 1
         ps = 8'h00;
         rx_chk <= 1'b0;
      end else begin
         if (rx_chk) begin
            `CHK("restored", {1'b1, exp_rx}, {rx_valid, rx_sample});
         end
         rx_chk <= 1'b0;
         if (sample_valid && sample_ready && clk_en) q.push_back(sample_data);
         if (frame_valid && frame_ready && clk_en && check_on && !preamble_active) begin
            s = (q.size() > 0) ? q.pop_front() : 16'hxxxx;
            k = mon && (scr ? frame_out.second == frame_align_pkg::K28_7 : !pk && s[7:0] == ps);
            `CHK("second_k", k, frame_out.second_k);
            if (!scr) begin
               `CHK("octets", {s[15:8], k ? frame_align_pkg::K28_7 : s[7:0]},
                  {frame_out.first, frame_out.second});
            end
            // the receiver must rebuild the sample in every mode
            exp_rx = s;
            rx_chk <= 1'b1;
            ps = s[7:0];
            pk = k;
         end
      end
   end

   // hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("tests %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   task automatic restart(input int n);
      // raise reset just after an edge, never in the edge's own time step
      @(posedge core_clk);
      #1 rst = 1'b1;
      repeat (n) @(posedge core_clk);
      #1 rst = 1'b0;
   endtask : restart

   // stream, then fill against a stalled receiver, then drain
   task automatic run_data(input logic m, input logic sc);
      int i;
      restart(2);
      mon = m;
      scr = sc;
      check_on = 1'b1;
      feed = 1'b1;
      repeat (400) @(posedge core_clk);
      hold_stall = 1'b1;
      repeat (40) @(posedge core_clk);
      #2 `CHK("fifo full", 1'b0, sample_ready);
      feed = 1'b0;
      hold_stall = 1'b0;
      for (i = 0; i < 200 && (q.size() > 0 || frame_valid); i++) @(posedge core_clk);
      `CHK("drained", 0, q.size());
      `CHK("realign", 1'b0, realign);
      check_on = 1'b0;
   endtask : run_data

   // every test pattern code
   task automatic pattern_test;
      int p, j, chg;
      for (p = 1; p < 4; p++) begin
         restart(2);
         pat = p[1:0];
         chg = 0;
         repeat (4) @(posedge core_clk);
         for (j = 0; j < 16; j++) begin
            prev = {frame_out.first, frame_out.second};
            @(posedge core_clk);
            #2 `CHK("pattern k", 2'b00, {frame_out.first_k, frame_out.second_k});
            if (p == 1) begin
               `CHK("alt", {frame_align_pkg::D21_5, frame_align_pkg::D21_5}, {frame_out.first, frame_out.second});
            end
            if ({frame_out.first, frame_out.second} != prev) chg++;
         end
         if (p > 1) begin
            `CHK("prbs moves", 1'b1, chg > 0);
         end
      end
      pat = 2'b00;
   endtask : pattern_test

   // short request is ignored, a held one gives commas
   task automatic sync_test;
      int i;
      restart(2);
      want_sync = 1'b1;
      @(posedge core_clk);
      #1 want_sync = 1'b0;
      seen = 1'b0;
      for (i = 0; i < 12; i++) begin
         @(posedge core_clk);
         #2 seen = seen | preamble_active;
      end
      `CHK("short request", 1'b0, seen);
      want_sync = 1'b1;
      for (i = 0; i < 20 && preamble_active !== 1'b1; i++) @(posedge core_clk);
      #2 `CHK("preamble", 1'b1, preamble_active);
      `CHK("comma", {frame_align_pkg::K28_5, 1'b1, frame_align_pkg::K28_5, 1'b1}, frame_out);
      want_sync = 1'b0;
      for (i = 0; i < 20 && preamble_active !== 1'b0; i++) @(posedge core_clk);
      #2 `CHK("preamble ends", 1'b0, preamble_active);
   endtask : sync_test

   // all four rate select combinations
   task automatic pll_test;
      int i;
      for (i = 0; i < 4; i++) begin
         rsel = i[1:0];
         er = !rsel[1] ? frame_align_pkg::RANGE_LOW :
            (rsel[0] ? frame_align_pkg::RANGE_HIGH : frame_align_pkg::RANGE_MID);
         #1 `CHK("pll range", er, pll_range);
      end
   endtask : pll_test

   initial begin
      restart(16);
      run_data(1'b0, 1'b0);
      run_data(1'b1, 1'b0);
      run_data(1'b0, 1'b1);
      run_data(1'b1, 1'b1);
      pattern_test();
      sync_test();
      pll_test();
      tally_and_finish();
   end
endmodule : serial_frame_align_monitor_test
